// >>> src/rmw_pkg.sv
// package: register map, field layout, reset values and timing for the rmw register bank
package rmw_pkg;
   localparam int unsigned NUM_GROUPS = 12;
   localparam int unsigned GRP_W = 8;
   localparam int unsigned GPIO_W = 16;
   localparam int unsigned AW = 8;
   // register byte offsets
   localparam logic [AW-1:0] OFS_GIF_BASE = 8'h00;   // group flags, 12 words 0x00..0x2C
   localparam logic [AW-1:0] OFS_GIE_BASE = 8'h40;   // group enables, 12 words 0x40..0x6C
   localparam logic [AW-1:0] OFS_CIF = 8'h80;   // cpu flags, read only
   localparam logic [AW-1:0] OFS_CIF_OR = 8'h84;   // or into cpu flags
   localparam logic [AW-1:0] OFS_CIF_AND = 8'h88;   // and into cpu flags
   localparam logic [AW-1:0] OFS_ACK = 8'h8C;   // interrupt taken: group index
   localparam logic [AW-1:0] OFS_GPIO_DAT = 8'h90;
   localparam logic [AW-1:0] OFS_GPIO_SET = 8'h94;
   localparam logic [AW-1:0] OFS_GPIO_CLR = 8'h98;
   localparam logic [AW-1:0] OFS_GPIO_TGL = 8'h9C;
   localparam logic [AW-1:0] OFS_TCR = 8'hA0;
   localparam logic [AW-1:0] OFS_IRQ_STAT = 8'hA4;
   localparam logic [AW-1:0] OFS_IRQ_MASK = 8'hA8;
   // timer control fields
   localparam int unsigned TCR_STOP_BIT = 4;   // mask 0x0010
   localparam int unsigned TCR_OVF_BIT = 15;
   // irq status bit positions
   localparam int unsigned IRQ_GROUP = 0;
   localparam int unsigned IRQ_TOVF = 1;
   localparam int unsigned IRQ_W = 2;
   // reset values
   localparam logic [GPIO_W-1:0] GPIO_RST = 16'h0000;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
   // sensing lag from latch to readable level
   localparam int unsigned SENSE_LAG_NS = 30;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned SENSE_LAG_CYC = (SENSE_LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SETTLE_CYC = SENSE_LAG_CYC + 2;   // two sync flops ahead of the lag
   typedef struct packed {
      logic                 read;
      logic                 write;
      logic [AW-1:0]       address;
      logic [31:0]         writedata;
   } rmw_req_t;
   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } rmw_rsp_t;
endpackage : rmw_pkg

// >>> src/rmw_pin_sense.sv
// pin sense path: two-flop synchroniser plus fixed lag stages
`timescale 1ns/1ps
`default_nettype none
module rmw_pin_sense
   import rmw_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic [GPIO_W-1:0] pinIn,
   output logic      [GPIO_W-1:0] sensed,
   output logic                   settled
);
   logic [GPIO_W-1:0] syncA;
   logic [GPIO_W-1:0] syncB;
   logic [GPIO_W-1:0] lagPipe [SENSE_LAG_CYC];

   // first stage feeds only the second stage
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         syncA <= GPIO_RST;
         syncB <= GPIO_RST;
      end else begin
         syncA <= pinIn;
         syncB <= syncA;
      end
   end

   // extra lag models the input path delay
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < SENSE_LAG_CYC; i++) lagPipe[i] <= GPIO_RST;
      end else begin
         lagPipe[0] <= syncB;
         for (int i = 1; i < SENSE_LAG_CYC; i++) lagPipe[i] <= lagPipe[i-1];
      end
   end

   assign sensed = lagPipe[SENSE_LAG_CYC-1];
   assign settled = (lagPipe[SENSE_LAG_CYC-1] == syncB);
endmodule : rmw_pin_sense
`default_nettype wire

// >>> src/rmw_register_bank.sv
// rmw-sensitive register bank: group flags, cpu flags, gpio ports, timer control
`timescale 1ns/1ps
`default_nettype none
module rmw_register_bank
   import rmw_pkg::*;
#(
   parameter bit LATCH_READBACK = 1'b0   // older variant returns output latch
)
(
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   input  wire logic [AW-1:0]         avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   input  wire logic [NUM_GROUPS*GRP_W-1:0] periphEvent,
   input  wire logic                  timerOverflow,
   output logic                       timerStop,
   output logic [NUM_GROUPS-1:0]      cpuIntReq,
   input  wire logic [GPIO_W-1:0]     gpioPinIn,
   output logic      [GPIO_W-1:0]     gpioPinOut,
   output logic      [GPIO_W-1:0]     gpioPinOe_n,
   output logic                       irq
);
   logic [GRP_W-1:0]      grpFlags   [NUM_GROUPS];
   logic [GRP_W-1:0]      grpEnables [NUM_GROUPS];
   logic [NUM_GROUPS-1:0] cpuFlags;
   logic [GPIO_W-1:0]     gpioLatch;
   logic [GPIO_W-1:0]     gpioDir;
   logic [GPIO_W-1:0]     sensed;
   logic                  tcrOvf;
   logic [IRQ_W-1:0]      irqStat;
   logic [IRQ_W-1:0]      irqMask;
   logic                  rdDone;
   logic                  gpioWrPend;
   logic [2:0]            settleCnt;
   logic [31:0]           next_readdata;
   logic [GPIO_W-1:0]     wMask;
   logic                  wrAcc;
   logic                  rdAcc;
   logic                  isGpio;
   logic                  ackHit;
   logic [3:0]            ackGrp;
   logic [GRP_W-1:0]      ackBits;

   // byte lanes to a 16-bit write mask
   function automatic logic [GPIO_W-1:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[1]}}, {8{be[0]}}};
   endfunction

   // group register index from an address inside a 12-word window
   function automatic logic in_group(input logic [AW-1:0] a, input logic [AW-1:0] base);
      in_group = (a >= base) && (a < base + AW'(NUM_GROUPS * 4)) && (a[1:0] == 2'b00);
   endfunction

   function automatic logic [3:0] grp_idx(input logic [AW-1:0] a, input logic [AW-1:0] base);
      logic [AW-1:0] d;
      d = a - base;
      grp_idx = d[5:2];
   endfunction

   rmw_pin_sense u_sense (
      .core_clk (core_clk),
      .rst      (rst),
      .pinIn    (gpioPinIn),
      .sensed   (sensed),
      .settled  ()
   );

   assign wMask = lane_mask(avs_byteenable);
   assign isGpio = (avs_address >= OFS_GPIO_DAT) && (avs_address <= OFS_GPIO_TGL);

   // a gpio read is held off while a gpio write is still settling; other reads are not held off, and writes are always single-cycle
   assign wrAcc = avs_write;
   assign rdAcc = avs_read && !rdDone && !(isGpio && gpioWrPend);
   assign avs_waitrequest = avs_read && !rdDone;

   // the ack write names the interrupt being taken: bits 3:0 group, bits 10:8 bit
   assign ackHit = wrAcc && (avs_address == OFS_ACK);
   assign ackGrp = avs_writedata[3:0];
   assign ackBits = GRP_W'(1) << avs_writedata[10:8];

   // group flags: event set beats both write and acknowledge clear
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int g = 0; g < NUM_GROUPS; g++) grpFlags[g] <= '0;
      end else begin
         for (int g = 0; g < NUM_GROUPS; g++) begin
            logic [GRP_W-1:0] v;
            v = grpFlags[g];
            if (wrAcc && in_group(avs_address, OFS_GIF_BASE) && grp_idx(avs_address, OFS_GIF_BASE) == 4'(g)
                && avs_byteenable[0])
               v = avs_writedata[GRP_W-1:0];
            if (ackHit && ackGrp == 4'(g))
               v = v & ~ackBits;
            grpFlags[g] <= v | periphEvent[g*GRP_W +: GRP_W];
         end
      end
   end

   // group enables are plain storage
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int g = 0; g < NUM_GROUPS; g++) grpEnables[g] <= '0;
      end else if (wrAcc && in_group(avs_address, OFS_GIE_BASE) && avs_byteenable[0]) begin
         grpEnables[grp_idx(avs_address, OFS_GIE_BASE)] <= avs_writedata[GRP_W-1:0];
      end
   end

   // cpu flags: a group line sets, or/and writes modify, never a plain store
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cpuFlags <= '0;
      end else begin
         logic [NUM_GROUPS-1:0] c;
         logic [NUM_GROUPS-1:0] lines;
         c = cpuFlags;
         for (int g = 0; g < NUM_GROUPS; g++) lines[g] = |(grpFlags[g] & grpEnables[g]);
         if (wrAcc && avs_address == OFS_CIF_OR) c = c | avs_writedata[NUM_GROUPS-1:0];
         if (wrAcc && avs_address == OFS_CIF_AND) c = c & avs_writedata[NUM_GROUPS-1:0];
         cpuFlags <= c | lines;
      end
   end

   // forwarding to the core needs both flag and enable
   always_comb begin
      for (int g = 0; g < NUM_GROUPS; g++) cpuIntReq[g] = cpuFlags[g] && |(grpFlags[g] & grpEnables[g]);
   end

   // output latch: data store, or set/clear/toggle acting on written ones only
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         gpioLatch <= GPIO_RST;
      end else if (wrAcc) begin
         unique case (avs_address)
            OFS_GPIO_DAT: gpioLatch <= (gpioLatch & ~wMask) | (avs_writedata[GPIO_W-1:0] & wMask);
            OFS_GPIO_SET: gpioLatch <= gpioLatch | (avs_writedata[GPIO_W-1:0] & wMask);
            OFS_GPIO_CLR: gpioLatch <= gpioLatch & ~(avs_writedata[GPIO_W-1:0] & wMask);
            OFS_GPIO_TGL: gpioLatch <= gpioLatch ^ (avs_writedata[GPIO_W-1:0] & wMask);
            default: gpioLatch <= gpioLatch;
         endcase
      end
   end

   // all pins driven from the first edge after reset, released in reset: enable is active low
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) gpioDir <= '0;
      else gpioDir <= '1;
   end
   assign gpioPinOut = gpioLatch;
   assign gpioPinOe_n = ~gpioDir;

   // a gpio write holds gpio reads off until its level has crossed sync and lag stages;
   // a fixed count, since a pin that never follows must not stall reads for good
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         settleCnt <= '0;
      end else if (wrAcc && isGpio) begin
         settleCnt <= 3'(SETTLE_CYC);
      end else if (settleCnt != '0) begin
         settleCnt <= settleCnt - 3'h1;
      end
   end
   assign gpioWrPend = (settleCnt != '0);

   // timer control: stop bit stored, overflow flag write-one-to-clear
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         timerStop <= 1'b0;
      end else if (wrAcc && avs_address == OFS_TCR && avs_byteenable[0]) begin
         timerStop <= avs_writedata[TCR_STOP_BIT];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tcrOvf <= 1'b0;
      end else if (timerOverflow) begin
         tcrOvf <= 1'b1;
      end else if (wrAcc && avs_address == OFS_TCR && avs_byteenable[1] && avs_writedata[TCR_OVF_BIT]) begin
         tcrOvf <= 1'b0;
      end
   end

   // sticky status, cleared by reading it; new events win over the read
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irqStat <= '0;
      end else begin
         logic [IRQ_W-1:0] ev;
         ev = '0;
         ev[IRQ_GROUP] = |cpuIntReq;
         ev[IRQ_TOVF] = timerOverflow;
         if (rdAcc && avs_address == OFS_IRQ_STAT) irqStat <= ev;
         else irqStat <= irqStat | ev;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) irqMask <= '0;
      else if (wrAcc && avs_address == OFS_IRQ_MASK) irqMask <= avs_writedata[IRQ_W-1:0];
   end
   assign irq = |(irqStat & irqMask);

   // read mux; reserved and unmapped bits read zero
   always_comb begin
      next_readdata = UNMAPPED_DATA;
      if (in_group(avs_address, OFS_GIF_BASE))
         next_readdata[GRP_W-1:0] = grpFlags[grp_idx(avs_address, OFS_GIF_BASE)];
      else if (in_group(avs_address, OFS_GIE_BASE))
         next_readdata[GRP_W-1:0] = grpEnables[grp_idx(avs_address, OFS_GIE_BASE)];
      else begin
         unique case (avs_address)
            OFS_CIF: next_readdata[NUM_GROUPS-1:0] = cpuFlags;
            OFS_GPIO_DAT: next_readdata[GPIO_W-1:0] = LATCH_READBACK ? gpioLatch : sensed;
            OFS_TCR: begin
               next_readdata[TCR_STOP_BIT] = timerStop;
               next_readdata[TCR_OVF_BIT] = tcrOvf;
            end
            OFS_IRQ_STAT: next_readdata[IRQ_W-1:0] = irqStat;
            OFS_IRQ_MASK: next_readdata[IRQ_W-1:0] = irqMask;
            default: next_readdata = UNMAPPED_DATA;  // set/clear/toggle read zero
         endcase
      end
   end

   // registered read: answer one cycle after the read is taken
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdDone <= 1'b0;
         avs_readdata <= '0;
      end else begin
         rdDone <= rdAcc;
         if (rdAcc) avs_readdata <= next_readdata;
      end
   end
endmodule : rmw_register_bank
`default_nettype wire

// >>> bench/rmw_checker.sv
// checker: port-level properties of the register bank
`timescale 1ns/1ps
`default_nettype none
module rmw_checker
   import rmw_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic [AW-1:0]     avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [31:0]       avs_readdata,
   input  wire logic              avs_waitrequest,
   input  wire logic              timerStop,
   input  wire logic [GPIO_W-1:0] gpioPinOut,
   input  wire logic [GPIO_W-1:0] gpioPinOe_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // decoded strobes; gpio frame is 0x90..0x9F
   wire logic gpioWr = avs_write && avs_address[7:4] == 4'h9;
   wire logic tcrWr = avs_write && avs_address == OFS_TCR;
   wire logic ans = avs_read && !avs_waitrequest;
   sequence readStart; $rose(avs_read); endsequence
   sequence readAnswered; ##[1:40] !avs_waitrequest; endsequence
   read_latency_a: assert property (readStart |-> readAnswered)
      else $error("read not answered in time");
   wait_only_read_a: assert property (avs_waitrequest |-> avs_read)
      else $error("wait without a read");
   stop_write_a: assert property (tcrWr |=> timerStop == $past(avs_writedata[TCR_STOP_BIT]))
      else $error("stop bit not stored");
   stop_hold_a: assert property (!tcrWr |=> $stable(timerStop))
      else $error("stop bit changed without write");
   stop_read_a: assert property (ans && avs_address == OFS_TCR |-> avs_readdata[TCR_STOP_BIT] == timerStop)
      else $error("stop bit readback wrong");
   port_zero_a: assert property (ans && avs_address inside {8'h94, 8'h98, 8'h9C} |-> avs_readdata == 32'h0)
      else $error("set clear toggle read nonzero");
   set_ones_a: assert property (avs_write && avs_address == OFS_GPIO_SET
      |=> gpioPinOut == ($past(gpioPinOut) | $past(avs_writedata[15:0])))
      else $error("set port wrong");
   clr_ones_a: assert property (avs_write && avs_address == OFS_GPIO_CLR
      |=> gpioPinOut == ($past(gpioPinOut) & ~$past(avs_writedata[15:0])))
      else $error("clear port wrong");
   tgl_ones_a: assert property (avs_write && avs_address == OFS_GPIO_TGL
      |=> gpioPinOut == ($past(gpioPinOut) ^ $past(avs_writedata[15:0])))
      else $error("toggle port wrong");
   out_quiet_a: assert property (!gpioWr |=> $stable(gpioPinOut))
      else $error("outputs disturbed");
   pins_driven_a: assert property ($past(rst) == 1'b0 |-> gpioPinOe_n == 16'h0000)
      else $error("pins not driven");
endmodule // rmw_checker
bind rmw_register_bank rmw_checker chk (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .timerStop(timerStop), .gpioPinOut(gpioPinOut),
   .gpioPinOe_n(gpioPinOe_n));
`default_nettype wire

// >>> bench/rmw_cpu_model.sv
// cpu core model: avalon master issuing plain and read-modify-write accesses
`timescale 1ns/1ps
`default_nettype none
module rmw_cpu_model
   import rmw_pkg::*;
(
   input  wire logic          core_clk,
   input  wire logic          waitrequest,
   input  wire logic [31:0]   readdata,
   output logic      [AW-1:0] address,
   output logic               read,
   output logic               write,
   output logic      [31:0]   writedata,
   output logic      [3:0]    byteenable
);
   // idle bus at time zero; all lanes always enabled
   initial begin
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      byteenable = 4'hF;
   end
   // leading edge keeps back-to-back calls from driving a strobe twice
   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
      @(posedge core_clk);
      address <= a;
      writedata <= d;
      write <= 1'b1;
      do @(posedge core_clk); while (waitrequest !== 1'b0);
      write <= 1'b0;
   endtask
   task automatic rd(input logic [AW-1:0] a, output logic [31:0] d);
      @(posedge core_clk);
      address <= a;
      read <= 1'b1;
      do @(posedge core_clk); while (waitrequest !== 1'b0);
      d = readdata;
      read <= 1'b0;
   endtask
   // every bit read goes back, so a w1c bit read as one gets cleared
   task automatic rmw(input logic [AW-1:0] a, input logic [31:0] orMask, output logic [31:0] d);
      rd(a, d);
      wr(a, d | orMask);
   endtask
endmodule // rmw_cpu_model
`default_nettype wire

// >>> bench/tb.sv
// testbench: register bank driven by the cpu model, pins looped back
`timescale 1ns/1ps
`default_nettype none
module tb
   import rmw_pkg::*;
;
   logic core_clk, rst, rdS, wrS, wreq, timerOverflow, timerStop, irq;
   logic [AW-1:0] adr;
   logic [31:0] wd, rdat, d;
   logic [3:0] be;
   logic [95:0] periphEvent;
   logic [11:0] cpuIntReq;
   logic [15:0] pinIn, pinOut, pinOeN, pinFlip;
   int n_errors, checks_done;
   localparam logic [7:0] GA[3] = '{8'h94, 8'h98, 8'h9C};
   localparam logic [31:0] GD[3] = '{32'h6, 32'h1, 32'h3};
   localparam logic [31:0] GE[3] = '{32'h8007, 32'h8006, 32'h8005};
   // released pins pull up; pinFlip models an external short
   assign pinIn = (pinOut | pinOeN) ^ pinFlip;
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   rmw_cpu_model cpu (.core_clk(core_clk), .waitrequest(wreq), .readdata(rdat), .address(adr),
      .read(rdS), .write(wrS), .writedata(wd), .byteenable(be));
   rmw_register_bank DUT (.core_clk(core_clk), .rst(rst), .avs_address(adr), .avs_read(rdS),
      .avs_write(wrS), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
      .avs_waitrequest(wreq), .periphEvent(periphEvent), .timerOverflow(timerOverflow),
      .timerStop(timerStop), .cpuIntReq(cpuIntReq), .gpioPinIn(pinIn), .gpioPinOut(pinOut),
      .gpioPinOe_n(pinOeN), .irq(irq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [AW-1:0] a, input logic [31:0] exp);
      logic [31:0] v;
      cpu.rd(a, v);
      chk(v, exp);
   endtask
   // one-cycle pulses, then wait for settled outputs
   task automatic ev(input int i);
      @(posedge core_clk);
      periphEvent[i] <= 1'b1;
      @(posedge core_clk);
      periphEvent[i] <= 1'b0;
      @(negedge core_clk);
   endtask
   task automatic ovf;
      @(posedge core_clk);
      timerOverflow <= 1'b1;
      @(posedge core_clk);
      timerOverflow <= 1'b0;
      @(negedge core_clk);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // watchdog well above the few hundred cycles the tests need
   initial begin
      #200000;
      n_errors++;
      tally_and_finish();
   end
   initial begin
      rst = 1'b1;
      periphEvent = '0;
      timerOverflow = 1'b0;
      pinFlip = 16'h8000;
      n_errors = 0;
      checks_done = 0;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      rdchk(OFS_TCR, 32'h0);
      rdchk(8'h08, 32'h0);
      // group 2 bit 3 is event line 19
      ev(19);
      rdchk(8'h08, 32'h08);
      chk(32'(cpuIntReq), 32'h0);
      cpu.wr(8'h48, 32'h08);
      // enable lands first, the group line reaches the cpu flags one edge later
      repeat (2) @(negedge core_clk);
      chk(32'(cpuIntReq), 32'h4);
      cpu.wr(OFS_CIF, 32'h0);
      rdchk(OFS_CIF, 32'h4);
      cpu.wr(OFS_ACK, 32'h0302);
      rdchk(8'h08, 32'h0);
      cpu.wr(8'h48, 32'h0);
      cpu.wr(OFS_CIF_AND, 32'h0);
      rdchk(OFS_CIF, 32'h0);
      cpu.wr(OFS_CIF_OR, 32'h820);
      cpu.wr(OFS_CIF_AND, 32'h020);
      rdchk(OFS_CIF, 32'h020);
      ev(19);
      cpu.wr(8'h08, 32'h0);
      rdchk(8'h08, 32'h0);
      @(posedge core_clk);
      periphEvent[19] <= 1'b1;
      cpu.wr(8'h08, 32'h0);
      periphEvent[19] <= 1'b0;
      rdchk(8'h08, 32'h08);
      $display("test group flags done");
      rdchk(OFS_GPIO_DAT, 32'h8000);
      cpu.wr(OFS_GPIO_DAT, 32'h1);
      rdchk(OFS_GPIO_DAT, 32'h8001);
      for (int i = 0; i < 3; i++) begin
         cpu.wr(GA[i], GD[i]);
         rdchk(OFS_GPIO_DAT, GE[i]);
         rdchk(GA[i], 32'h0);
      end
      $display("test gpio done");
      ovf();
      rdchk(OFS_TCR, 32'h8000);
      cpu.wr(OFS_TCR, 32'h0010);
      rdchk(OFS_TCR, 32'h8010);
      chk(32'(timerStop), 32'h1);
      cpu.rmw(OFS_TCR, 32'h0010, d);
      chk(d, 32'h8010);
      rdchk(OFS_TCR, 32'h0010);
      cpu.wr(OFS_TCR, 32'h0);
      @(negedge core_clk);
      chk(32'(timerStop), 32'h0);
      $display("test timer done");
      cpu.rd(OFS_IRQ_STAT, d);
      cpu.wr(OFS_IRQ_MASK, 32'h2);
      ovf();
      chk(32'(irq), 32'h1);
      rdchk(OFS_IRQ_STAT, 32'h2);
      @(negedge core_clk);
      chk(32'(irq), 32'h0);
      cpu.wr(OFS_IRQ_MASK, 32'h0);
      ovf();
      chk(32'(irq), 32'h0);
      rdchk(OFS_IRQ_STAT, 32'h2);
      cpu.wr(8'hFC, 32'hFFFF);
      rdchk(8'hFC, UNMAPPED_DATA);
      $display("test irq and unmapped done");
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
